// file: src/can_gc_consts.vh
// Constants for the two-channel CAN global control block.
// Included by the design files; holds definitions only.
`ifndef CAN_GC_CONSTS_VH
`define CAN_GC_CONSTS_VH

// Register addresses on the CPU access port
`define CAN0_GLOBAL_CONTROL_ADDR 20'hf05c0
`define CAN0_BLOCK_TX_CONTROL_ADDR 20'hf05c6
`define CAN0_CLOCK_PRESCALER_ADDR 20'hf05ce
`define CAN1_GLOBAL_CONTROL_ADDR 20'hf0340
`define CAN1_CLOCK_PRESCALER_ADDR 20'hf0342
`define CAN1_BLOCK_TX_CONTROL_ADDR 20'hf0346
`define PERIPHERAL_CLOCK_SELECT_ADDR 20'hf00f0

// Reset values
`define GLOBAL_CONTROL_RST 16'h0000
`define CLOCK_PRESCALER_RST 4'hf
`define BLOCK_TX_CONTROL_RST 16'h0000
`define PERIPHERAL_CLOCK_SELECT_RST 8'h00

// Global control fields
`define GC_BUF_ACCESS_BIT 15
`define GC_SET_SHUTDOWN_BIT 9
`define GC_SET_OPERATE_BIT 8
`define GC_SHUTDOWN_BIT 1
`define GC_OPERATE_BIT 0
`define GC_CLR_OPERATE_BIT 0

// Block transmission control fields
`define BT_SET_CLEAR_BIT 9
`define BT_CLEAR_STATUS_BIT 1
`define BT_RUNNING_BIT 0

// Peripheral clock select: per channel n, enable at 2n, choice at 2n+1
`define PCS_ENABLE_OFS 0
`define PCS_CHOICE_OFS 1

// Prescaler field width
`define PRESCALER_W 4

`endif

// file: src/set_clear_merge.v
// Set/clear write encoding for one group of control bits.
// Pure combinational; the caller decides when the result is stored.
`timescale 1ns/1ps
module set_clear_merge #(
  parameter W = 8
) (
  // Current value and write request halves
  input wire [W-1:0] cur,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  // Value after the write
  output wire [W-1:0] nxt
);
  // Set only gives 1, clear only gives 0, both or neither keeps the bit
  assign nxt = (set & ~clr) | (cur & ~(set ^ clr));
endmodule

// file: src/clock_prescaler.v
// Divides the channel input clock into a module system clock tick.
// Counts only while the channel clock is supplied; one clock domain.
`timescale 1ns/1ps
`include "can_gc_consts.vh"
module clock_prescaler #(
  parameter W = `PRESCALER_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire run,
  input wire [W-1:0] div,
  // One-cycle tick every div+1 input clocks
  output reg tick
);
  reg [W-1:0] cnt_q;

  always @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule

// file: src/can_global_control.v
// Global control registers of a two-channel CAN controller: clock select,
// operation enable, buffer access gating, forced shutdown, prescaler and
// block transmission status. Runs in the single CLOCK domain; the CPU access
// port and all status inputs are synchronous to CLOCK.
`timescale 1ns/1ps
`include "can_gc_consts.vh"
module can_global_control #(
  parameter NCH = 2,
  parameter AW = 20
) (
  // Clock and reset
  input wire CLOCK,
  input wire SYS_RST,
  // CPU register access
  input wire [AW-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // Channel state from the protocol core
  input wire [NCH-1:0] INIT_MODE,
  input wire [NCH-1:0] SLEEP_STOP,
  input wire [NCH-1:0] BLK_TX_RUNNING,
  input wire [NCH-1:0] BLK_CLEAR_DONE,
  // Channel clock control
  output wire [NCH-1:0] CLK_RUN,
  output wire [NCH-1:0] CLK_FROM_PERIPH,
  output wire [NCH-1:0] CHAN_REG_EN,
  output wire [NCH-1:0] SYSCLK_TICK,
  // Channel operation control
  output wire [NCH-1:0] MODULE_ENABLE,
  output wire [NCH-1:0] BUF_ACCESS_EN,
  output wire [NCH-1:0] BLK_CLEAR_REQ,
  output wire [NCH-1:0] FORCED_SHUTDOWN
);
  // Shared state and decode
  reg [7:0] clk_sel_q;
  reg [15:0] rdata_d;
  wire any_access;
  wire hit_sel;
  wire [NCH-1:0] hit_ctl;
  wire [NCH-1:0] hit_cs;
  wire [NCH-1:0] hit_blk;
  wire [16*NCH-1:0] rd_words;
  integer k;

  // Any access, to any address, ends a pending shutdown arm
  assign any_access = WR | RD;
  assign hit_sel = (ADDR == `PERIPHERAL_CLOCK_SELECT_ADDR);

  // Peripheral clock select, written as a byte
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      clk_sel_q <= `PERIPHERAL_CLOCK_SELECT_RST;
    end else if (WR && hit_sel) begin
      clk_sel_q <= WDATA[7:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      // Per-channel control state
      reg operate_q;
      reg operate_d;
      reg shut_arm_q;
      reg shut_arm_d;
      reg buf_ok_q;
      reg buf_ok_d;
      reg sleep_prev_q;
      reg eng_clr_q;
      reg eng_clr_d;
      reg shut_pulse_q;
      reg shut_pulse_d;
      reg [`PRESCALER_W-1:0] presc_q;
      reg [15:0] rd_word_d;
      wire en;
      wire operate_sc;
      wire clear_req;
      wire clear_ok;
      wire op_fall;
      wire op_rise;
      wire sleep_enter;
      wire sleep_leave;
      wire wr_ctl;
      wire rd_ctl;
      wire wr_cs;
      wire rd_cs;
      wire wr_blk;
      wire rd_blk;
      wire [AW-1:0] a_ctl;
      wire [AW-1:0] a_cs;
      wire [AW-1:0] a_blk;

      assign en = clk_sel_q[2*i+`PCS_ENABLE_OFS];
      assign a_ctl = (i == 0) ? `CAN0_GLOBAL_CONTROL_ADDR : `CAN1_GLOBAL_CONTROL_ADDR;
      assign a_cs = (i == 0) ? `CAN0_CLOCK_PRESCALER_ADDR : `CAN1_CLOCK_PRESCALER_ADDR;
      assign a_blk = (i == 0) ? `CAN0_BLOCK_TX_CONTROL_ADDR : `CAN1_BLOCK_TX_CONTROL_ADDR;

      // Channel registers only answer while the channel clock runs
      assign hit_ctl[i] = (ADDR == a_ctl) & en;
      assign hit_cs[i] = (ADDR == a_cs) & en;
      assign hit_blk[i] = (ADDR == a_blk) & en;

      // Access qualifiers per register
      assign wr_ctl = WR & hit_ctl[i];
      assign rd_ctl = RD & hit_ctl[i];
      assign wr_cs = WR & hit_cs[i];
      assign rd_cs = RD & hit_cs[i];
      assign wr_blk = WR & hit_blk[i];
      assign rd_blk = RD & hit_blk[i];

      // Clock supply and status outputs
      assign CLK_RUN[i] = en;
      assign CLK_FROM_PERIPH[i] = en & clk_sel_q[2*i+`PCS_CHOICE_OFS];
      assign CHAN_REG_EN[i] = en;
      assign MODULE_ENABLE[i] = operate_q;
      assign BUF_ACCESS_EN[i] = buf_ok_q;
      assign BLK_CLEAR_REQ[i] = eng_clr_q;
      assign FORCED_SHUTDOWN[i] = shut_pulse_q;

      // Operate enable uses the paired set/clear encoding
      set_clear_merge #(
        .W(1)
      ) u_operate (
        .cur(operate_q),
        .set(WDATA[`GC_SET_OPERATE_BIT]),
        .clr(WDATA[`GC_CLR_OPERATE_BIT]),
        .nxt(operate_sc)
      );

      // A lone clear is only taken in initialization or as the shutdown step
      assign clear_req = WDATA[`GC_CLR_OPERATE_BIT] & ~WDATA[`GC_SET_OPERATE_BIT];
      assign clear_ok = INIT_MODE[i] | shut_arm_q;
      assign op_fall = operate_q & ~operate_d;
      assign op_rise = ~operate_q & operate_d;
      assign sleep_enter = SLEEP_STOP[i] & ~sleep_prev_q;
      assign sleep_leave = ~SLEEP_STOP[i] & sleep_prev_q;

      clock_prescaler #(
        .W(`PRESCALER_W)
      ) u_presc (
        .clk(CLOCK),
        .rst(SYS_RST),
        .run(en),
        .div(presc_q),
        .tick(SYSCLK_TICK[i])
      );

      // Operate enable next value
      always @* begin
        operate_d = operate_q;
        if (wr_ctl) begin
          if (clear_req && !clear_ok) begin
            operate_d = operate_q;
          end else begin
            operate_d = operate_sc;
          end
        end
      end

      // Shutdown arm lasts exactly one following access
      always @* begin
        shut_arm_d = shut_arm_q;
        shut_pulse_d = 1'b0;
        if (wr_ctl) begin
          shut_pulse_d = shut_arm_q & op_fall;
        end
        if (wr_ctl && WDATA[`GC_SET_SHUTDOWN_BIT]) begin
          shut_arm_d = 1'b1;
        end else if (any_access) begin
          shut_arm_d = 1'b0;
        end
      end

      // Buffer access follows operate enable and sleep/stop transitions
      always @* begin
        buf_ok_d = buf_ok_q;
        if (op_fall || sleep_enter) begin
          buf_ok_d = 1'b0;
        end else if (op_rise || (sleep_leave && operate_q)) begin
          buf_ok_d = 1'b1;
        end
      end

      // A new clear request wins over a completion in the same cycle
      always @* begin
        eng_clr_d = eng_clr_q;
        if (wr_blk && WDATA[`BT_SET_CLEAR_BIT]) begin
          eng_clr_d = 1'b1;
        end else if (BLK_CLEAR_DONE[i]) begin
          eng_clr_d = 1'b0;
        end
      end

      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          operate_q <= 1'b0;
          shut_arm_q <= 1'b0;
          buf_ok_q <= 1'b0;
          sleep_prev_q <= 1'b0;
          eng_clr_q <= 1'b0;
          shut_pulse_q <= 1'b0;
        end else begin
          operate_q <= operate_d;
          shut_arm_q <= shut_arm_d;
          buf_ok_q <= buf_ok_d;
          sleep_prev_q <= SLEEP_STOP[i];
          eng_clr_q <= eng_clr_d;
          shut_pulse_q <= shut_pulse_d;
        end
      end

      // Prescaler field register
      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          presc_q <= `CLOCK_PRESCALER_RST;
        end else if (wr_cs) begin
          presc_q <= WDATA[`PRESCALER_W-1:0];
        end
      end

      // Read word; the buffer access flag is a read-only status
      always @* begin
        case ({rd_blk, rd_cs, rd_ctl})
          3'b001: begin
            rd_word_d = {buf_ok_q, 13'h0000, shut_arm_q, operate_q};
          end
          3'b010: begin
            rd_word_d = {12'h000, presc_q};
          end
          3'b100: begin
            rd_word_d = {14'h0000, eng_clr_q, BLK_TX_RUNNING[i]};
          end
          default: begin
            rd_word_d = 16'h0000;
          end
        endcase
      end

      assign rd_words[16*i +: 16] = rd_word_d;
    end
  endgenerate

  // Read data, one cycle after the read strobe; unmapped reads give zero
  always @* begin
    rdata_d = {16{RD & hit_sel}} & {8'h00, clk_sel_q};
    for (k = 0; k < NCH; k = k + 1) begin
      rdata_d = rdata_d | rd_words[16*k +: 16];
    end
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= rdata_d;
    end
  end
endmodule

// file: dv/can_gc_properties.sv
// Assertions on the CAN global control ports, channel 0; the register gate check covers both channels.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "can_gc_consts.vh"
module can_gc_properties #(
  parameter NCH = 2,
  parameter AW = 20
) (
  // Clock, reset and access port
  input logic CLOCK,
  input logic SYS_RST,
  input logic [AW-1:0] ADDR,
  input logic [15:0] WDATA,
  input logic WR,
  // Channel status and control
  input logic [NCH-1:0] BLK_CLEAR_DONE,
  input logic [NCH-1:0] CLK_RUN,
  input logic [NCH-1:0] CLK_FROM_PERIPH,
  input logic [NCH-1:0] CHAN_REG_EN,
  input logic [NCH-1:0] MODULE_ENABLE,
  input logic [NCH-1:0] BUF_ACCESS_EN,
  input logic [NCH-1:0] BLK_CLEAR_REQ,
  input logic [NCH-1:0] FORCED_SHUTDOWN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_gc0(d);
    WR && ADDR == `CAN0_GLOBAL_CONTROL_ADDR && WDATA == d && CLK_RUN[0];
  endsequence
  a_reg_gate: assert property (CHAN_REG_EN == CLK_RUN)
    else $error("register enable differs from clock run");
  a_clock_off: assert property (!CLK_RUN[0] |-> !CLK_FROM_PERIPH[0])
    else $error("clock choice shown while clock stopped");
  a_gated_write: assert property (WR && !CLK_RUN[0] |=> $stable(MODULE_ENABLE[0]))
    else $error("write took effect with clock stopped");
  a_operate_set: assert property (s_gc0(16'h0100) |=> MODULE_ENABLE[0])
    else $error("operate enable not set");
  a_buf_drop: assert property ($fell(MODULE_ENABLE[0]) |-> !BUF_ACCESS_EN[0])
    else $error("buffer access kept after operate clear");
  a_buf_rise: assert property ($rose(MODULE_ENABLE[0]) |-> BUF_ACCESS_EN[0])
    else $error("buffer access not granted on operate set");
  a_forced_stop: assert property (MODULE_ENABLE[0] ##0 s_gc0(16'h0200) ##1 s_gc0(16'h0001)
    |=> FORCED_SHUTDOWN[0] && !MODULE_ENABLE[0])
    else $error("forced shutdown not carried out");
  a_pulse_once: assert property (FORCED_SHUTDOWN[0] |=> !FORCED_SHUTDOWN[0])
    else $error("shutdown pulse longer than one cycle");
  a_clear_ends: assert property (BLK_CLEAR_REQ[0] && BLK_CLEAR_DONE[0] && !WR
    |=> !BLK_CLEAR_REQ[0])
    else $error("clear status stuck after completion");
  a_clear_holds: assert property (BLK_CLEAR_REQ[0] && !BLK_CLEAR_DONE[0] && CLK_RUN[0]
    |=> BLK_CLEAR_REQ[0])
    else $error("clear status dropped early");
endmodule
bind can_global_control can_gc_properties #(.NCH(NCH), .AW(AW)) u_props (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .BLK_CLEAR_DONE(BLK_CLEAR_DONE),
  .CLK_RUN(CLK_RUN), .CLK_FROM_PERIPH(CLK_FROM_PERIPH), .CHAN_REG_EN(CHAN_REG_EN),
  .MODULE_ENABLE(MODULE_ENABLE), .BUF_ACCESS_EN(BUF_ACCESS_EN),
  .BLK_CLEAR_REQ(BLK_CLEAR_REQ), .FORCED_SHUTDOWN(FORCED_SHUTDOWN));

// file: dv/can_core_model.sv
// Behavioural protocol core: block transmission status and engine clear.
// Assumes clear requests come from the design; answers after lat cycles.
`timescale 1ns/1ps
module can_core_model (
  // Clock and bench controls
  input logic clk,
  input logic [1:0] go,
  input logic [3:0] lat,
  // Design side
  input logic [1:0] req,
  output logic [1:0] run,
  output logic [1:0] done
);
  logic [3:0] cnt [2];
  initial begin
    run = 0;
    done = 0;
    cnt = '{4'h0, 4'h0};
  end
  always @(posedge clk) begin
    run <= go;
  end
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= req[i] && !done[i] ? cnt[i] + 4'h1 : 4'h0;
      done[i] <= req[i] && !done[i] && cnt[i] == lat;
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the CAN global control block.
// Assumes the design, checker and core model are compiled before it.
`timescale 1ns/1ps
`include "can_gc_consts.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic CLOCK = 0, SYS_RST = 1, WR = 0, RD = 0, op = 0;
  logic [19:0] ADDR = 0;
  logic [15:0] WDATA = 0, RDATA;
  logic [1:0] INIT_MODE = 2'b11, SLEEP_STOP = 0, go = 0, BLK_TX_RUNNING, BLK_CLEAR_DONE;
  logic [1:0] CLK_RUN, CLK_FROM_PERIPH, CHAN_REG_EN, SYSCLK_TICK, MODULE_ENABLE;
  logic [1:0] BUF_ACCESS_EN, BLK_CLEAR_REQ, FORCED_SHUTDOWN;
  logic [3:0] lat = 0;
  logic [7:0] v;
  int num_errors = 0, checks = 0, n, k;
  localparam logic [19:0] G0 = `CAN0_GLOBAL_CONTROL_ADDR, PC = `PERIPHERAL_CLOCK_SELECT_ADDR;
  localparam logic [19:0] G1 = `CAN1_GLOBAL_CONTROL_ADDR, B0 = `CAN0_BLOCK_TX_CONTROL_ADDR;
  always #5 CLOCK = ~CLOCK;
  can_global_control u_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .INIT_MODE(INIT_MODE), .SLEEP_STOP(SLEEP_STOP),
    .BLK_TX_RUNNING(BLK_TX_RUNNING), .BLK_CLEAR_DONE(BLK_CLEAR_DONE), .CLK_RUN(CLK_RUN),
    .CLK_FROM_PERIPH(CLK_FROM_PERIPH), .CHAN_REG_EN(CHAN_REG_EN), .SYSCLK_TICK(SYSCLK_TICK),
    .MODULE_ENABLE(MODULE_ENABLE), .BUF_ACCESS_EN(BUF_ACCESS_EN),
    .BLK_CLEAR_REQ(BLK_CLEAR_REQ), .FORCED_SHUTDOWN(FORCED_SHUTDOWN));
  can_core_model u_core (.clk(CLOCK), .go(go), .lat(lat), .req(BLK_CLEAR_REQ),
    .run(BLK_TX_RUNNING), .done(BLK_CLEAR_DONE));
  function logic sc(input logic cur, s, c);
    return s ^ c ? s : cur;
  endfunction
  task acc(input logic w, r, input logic [19:0] a, input logic [15:0] d);
    @(negedge CLOCK);
    WR = w;
    RD = r;
    ADDR = a;
    WDATA = d;
  endtask
  task idle;
    @(negedge CLOCK);
    WR = 0;
    RD = 0;
  endtask
  task wr(input logic [19:0] a, input logic [15:0] d);
    acc(1, 0, a, d);
    idle;
  endtask
  task rdc(input logic [19:0] a, input logic [15:0] e);
    acc(0, 1, a, 0);
    idle;
    `CHK(RDATA, e)
  endtask
  // Skips two ticks so a divider change settles, then measures one period
  task gap;
    repeat (2) begin
      for (k = 0; k < 40 && SYSCLK_TICK[0] !== 1; k++) @(negedge CLOCK);
      @(negedge CLOCK);
    end
    for (k = 1; k < 40 && SYSCLK_TICK[0] !== 1; k++) @(negedge CLOCK);
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  initial begin
    v = $urandom(32'h68e6cef6);
    repeat (2) @(negedge CLOCK);
    SYS_RST = 0;
    rdc(G0, 0);
    rdc(PC, 0);
    for (n = 0; n < 6; n++) begin
      v = n == 0 ? 8'hff : $urandom;
      wr(PC, {8'h0, v});
      rdc(PC, {8'h0, v});
      `CHK({CLK_RUN, CHAN_REG_EN}, {2{v[2], v[0]}})
      `CHK(CLK_FROM_PERIPH, {v[3] & v[2], v[1] & v[0]})
    end
    wr(PC, 16'h0004);
    wr(G0, 16'h0100);
    wr(PC, 16'h0005);
    rdc(G0, 0);
    rdc(20'hf0000, 0);
    rdc(`CAN0_CLOCK_PRESCALER_ADDR, 16'h000f);
    for (n = 0; n < 4; n++) begin
      v = n == 0 ? 8'h0 : n == 1 ? 8'h0f : $urandom % 16;
      wr(`CAN0_CLOCK_PRESCALER_ADDR, {8'h0, v});
      gap;
      `CHK(k, int'(v) + 1)
    end
    wr(G0, 16'h0100);
    rdc(G0, 16'h8001);
    wr(G0, 16'h0101);
    rdc(G0, 16'h8001);
    wr(G0, 16'h0001);
    rdc(G0, 16'h0000);
    wr(G0, 16'h8000);
    rdc(G0, 16'h0000);
    INIT_MODE = 0;
    wr(G0, 16'h0100);
    wr(G0, 16'h0001);
    rdc(G0, 16'h8001);
    wr(G0, 16'h0200);
    rdc(G0, 16'h8003);
    rdc(G0, 16'h8001);
    wr(G0, 16'h0200);
    wr(PC, 16'h0005);
    wr(G0, 16'h0001);
    rdc(G0, 16'h8001);
    acc(1, 0, G0, 16'h0200);
    acc(1, 0, G0, 16'h0001);
    idle;
    `CHK({FORCED_SHUTDOWN, MODULE_ENABLE, BUF_ACCESS_EN}, 6'b010000)
    rdc(G0, 0);
    wr(G0, 16'h0100);
    SLEEP_STOP = 2'b01;
    repeat (2) @(negedge CLOCK);
    `CHK(BUF_ACCESS_EN, 2'b00)
    SLEEP_STOP = 0;
    repeat (2) @(negedge CLOCK);
    `CHK(BUF_ACCESS_EN, 2'b01)
    rdc(B0, 0);
    go = 2'b01;
    rdc(B0, 16'h0001);
    go = 0;
    for (n = 0; n < 2; n++) begin
      lat = n ? 4'h7 : 4'h0;
      wr(B0, 16'h0200);
      if (n) rdc(B0, 16'h0002);
      for (k = 0; k < 20 && BLK_CLEAR_REQ[0] !== 1'b0; k++) @(negedge CLOCK);
      rdc(B0, 0);
    end
    wr(B0, 16'h0000);
    rdc(B0, 0);
    INIT_MODE = 2'b11;
    for (n = 0; n < 8; n++) begin
      v = $urandom;
      wr(G1, {7'h0, v[1], 7'h0, v[0]});
      op = sc(op, v[1], v[0]);
      rdc(G1, {op, 14'h0, op});
    end
    give_verdict;
  end
endmodule
